// *** rtl/hms_seq.sv ***
`timescale 1ns/1ps
// What this block does
// (R01) code 0: here, or first index
// (R02) code 1: limit, back out, edge/index
// (R03) code 2: search, reverse at home switch
// (R04) code 2: limit before home is error
// (R05) code 3: limit reverses search instead
// (R06) code 3: edge bit picks searched edge
// (R07) code 4: move until current reaches threshold
// (R08) press at threshold until delay expires
// (R09) hard stop with index: drive away to index
// (R10) code 15: reference after encoder ready
// (R11) immediate: offset plus encoder loaded as position
// (R12) direction bit: 0 positive, 1 negative
// (R13) index bit: index pulse replaces sensor edge
// (R14) index select bit chooses which pulse
// (R15) index edge bit: set falling, clear rising
// (R16) home edge bit: set negative, clear positive
// (R17) zero bit: move to zero after homing, except after code 15
// (R18) no-adjust bit keeps actual position
// (R19) adjustment value loaded even when suppressed
// (R20) no-adjust bit suppresses move to zero
// (R21) calibration bit stores method and offset
// (R22) reserved codes refuse to start
module hms_seq
  import hms_pkg::*;
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RESETN,
  // configuration register port
  input wire logic I_CFG_WE,
  input wire logic [CFG_W-1:0] I_CFG_WDATA,
  output logic [CFG_W-1:0] O_CFG_RDATA,
  // homing parameters
  input wire logic signed [POS_W-1:0] I_HOME_OFFSET,
  input wire logic [CUR_W-1:0] I_CUR_THRESH,
  input wire logic [DLY_W-1:0] I_HOME_DELAY_MS,
  // control
  input wire logic I_START,
  input wire logic I_POWER_UP,
  input wire logic I_ENC_READY,
  // sensors
  input wire logic I_HOME_SW,
  input wire logic I_LIMIT_POS,
  input wire logic I_LIMIT_NEG,
  input wire logic I_INDEX,
  input wire logic [CUR_W-1:0] I_MOTOR_CUR,
  input wire logic signed [POS_W-1:0] I_ENC_POS,
  input wire logic I_AT_TARGET,
  // motion commands
  output logic O_MOVE,
  output logic O_MOVE_NEG,
  output logic O_SLOW,
  output logic O_PRESS,
  output logic O_GOTO_ZERO,
  // results
  output logic signed [POS_W-1:0] O_POSITION,
  output logic O_POS_LOAD,
  output logic signed [POS_W-1:0] O_HOME_ADJUST,
  output logic O_BUSY,
  output logic O_DONE,
  output logic O_ERROR,
  output logic O_REFUSED,
  // calibration store
  output logic O_CAL_STORE,
  output logic [CFG_W-1:0] O_CAL_CFG,
  output logic signed [POS_W-1:0] O_CAL_OFFSET
);
  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic meth_valid(input logic [3:0] m);
    meth_valid = (m <= M_HARD) || (m == M_IMMED);
  endfunction : meth_valid

  hms_state_t state_r;
  logic [CFG_W-1:0] cfg_r;
  logic [CFG_W-1:0] run_r;
  logic neg_r;
  logic found_r;
  logic signed [POS_W-1:0] pos_r;
  logic signed [POS_W-1:0] adj_r;
  logic load_r;
  logic cal_r;
  logic done_r;
  logic err_r;
  logic ref_r;
  logic imm_pend_r;
  logic [$clog2(TICK_CYC)-1:0] tick_cnt_r;
  logic tick;
  logic [DLY_W-1:0] dly_cnt_r;
  logic [3:0] meth;
  logic dir0;
  logic use_idx;
  logic idx_ev;
  logic home_ev;
  logic limit_ahead;
  logic over_cur;
  logic signed [POS_W-1:0] home_pos;
  logic finish;

  hms_edge_if edges ();

  hms_edge_det u_edge (
    .i_clk(I_CLK),
    .i_resetn(I_RESETN),
    .i_home(I_HOME_SW),
    .i_index(I_INDEX),
    .edges(edges)
  );

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  // run_r freezes the word so a write mid-sequence cannot change the plan
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
      cfg_r <= CFG_RESET;
    else if (I_CFG_WE)
      cfg_r <= I_CFG_WDATA;
  end
  assign O_CFG_RDATA = cfg_r;

  // field decode of the frozen word
  assign meth = run_r[F_METH_HI:F_METH_LO];
  assign dir0 = run_r[F_DIR]; // R12
  assign use_idx = run_r[F_IDX]; // R13
  // index edge selection
  assign idx_ev = run_r[F_IDXFALL] ? edges.idx_fall : edges.idx_rise; // R15
  // home edge: momentary switch uses the edge bit, else the edge met
  assign home_ev = (meth == M_INTER) ? (run_r[F_HOMENEG] ? edges.home_fall : edges.home_rise) // R06 R16
                 : (edges.home_rise | edges.home_fall);
  assign limit_ahead = neg_r ? I_LIMIT_NEG : I_LIMIT_POS;
  assign over_cur = I_MOTOR_CUR >= I_CUR_THRESH;
  assign home_pos = I_ENC_POS;
  assign finish = (state_r == ST_DONE);

  // ---------------------------------------------------------------
  // millisecond tick for the hard-stop delay
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
      tick_cnt_r <= '0;
    // restart at contact, so the first millisecond of the press is a whole one
    else if (state_r != ST_PRESS || !found_r || tick)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick_cnt_r + 1'b1;
  end
  assign tick = (tick_cnt_r == ($clog2(TICK_CYC))'(TICK_CYC - 1));

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // one process owns state, direction and the home adjustment
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      state_r <= ST_IDLE;
      run_r <= CFG_RESET;
      neg_r <= 1'b0;
      found_r <= 1'b0;
      dly_cnt_r <= '0;
      adj_r <= '0;
      ref_r <= 1'b0;
    end
    else
    begin
      ref_r <= 1'b0;
      unique case (state_r)
        ST_IDLE:
        begin
          found_r <= 1'b0;
          if (imm_pend_r && cfg_r[F_METH_HI:F_METH_LO] == M_IMMED)
          begin
            run_r <= cfg_r;
            state_r <= ST_WAITENC; // R10
          end
          else if (I_START)
          begin
            if (!meth_valid(cfg_r[F_METH_HI:F_METH_LO]))
              ref_r <= 1'b1; // R22
            else
            begin
              run_r <= cfg_r;
              neg_r <= cfg_r[F_DIR]; // R12
              if (cfg_r[F_METH_HI:F_METH_LO] == M_IMMED)
                state_r <= ST_WAITENC;
              else if (cfg_r[F_METH_HI:F_METH_LO] == M_HERE)
                state_r <= cfg_r[F_IDX] ? ST_INDEX : ST_DONE; // R01
              else if (cfg_r[F_METH_HI:F_METH_LO] == M_HARD)
                state_r <= ST_PRESS; // R07
              else
                state_r <= ST_SEARCH;
            end
          end
        end
        ST_SEARCH:
        begin
          if (meth == M_HARD)
          begin
            if (over_cur)
              state_r <= ST_PRESS;
          end
          else if (meth == M_LIMIT)
          begin
            if (limit_ahead)
            begin
              neg_r <= ~neg_r; // R02
              state_r <= ST_BACKOUT;
            end
          end
          else if (I_HOME_SW)
          begin
            neg_r <= ~neg_r; // R03
            state_r <= ST_BACKOUT;
          end
          else if (limit_ahead)
          begin
            if (meth == M_INTER)
              neg_r <= ~neg_r; // R05
            else
              state_r <= ST_ERROR; // R04
          end
        end
        ST_BACKOUT:
        begin
          // leave the sensor, slowly, and look for the edge
          if ((meth == M_LIMIT && !(neg_r ? I_LIMIT_POS : I_LIMIT_NEG)) || (meth != M_LIMIT && home_ev))
          begin
            if (use_idx)
            begin
              // select bit set: keep moving on the exit side; clear: turn to initial direction
              neg_r <= run_r[F_IDXSEL] ? neg_r : dir0; // R14
              state_r <= ST_INDEX; // R13
            end
            else
              state_r <= ST_DONE;
          end
          // wrong edge of a momentary switch: turn back and meet the other one
          else if (meth == M_INTER && (edges.home_rise | edges.home_fall))
            neg_r <= ~neg_r; // R06
        end
        ST_INDEX:
        begin
          if (idx_ev)
            state_r <= ST_DONE; // R01 R02 R13
        end
        ST_PRESS:
        begin
          // first wait for current, then hold for the delay
          if (!found_r)
          begin
            if (over_cur)
            begin
              found_r <= 1'b1; // R07
              dly_cnt_r <= I_HOME_DELAY_MS;
            end
          end
          else if (dly_cnt_r == '0)
          begin
            if (use_idx)
            begin
              neg_r <= ~neg_r;
              state_r <= ST_AWAY; // R09
            end
            else
              state_r <= ST_DONE;
          end
          else if (tick)
            dly_cnt_r <= dly_cnt_r - 1'b1; // R08
        end
        ST_AWAY:
        begin
          if (idx_ev)
            state_r <= ST_DONE; // R09
        end
        ST_WAITENC:
        begin
          if (I_ENC_READY)
            state_r <= ST_DONE; // R10
        end
        ST_DONE:
        begin
          // adjustment computed whether or not it is applied
          adj_r <= I_HOME_OFFSET - home_pos; // R19
          if (run_r[F_ZERO] && !run_r[F_NOADJ] && meth != M_IMMED) // R17 R20
            state_r <= ST_ZERO;
          else
            state_r <= ST_IDLE;
        end
        ST_ZERO:
        begin
          if (I_AT_TARGET)
            state_r <= ST_IDLE; // R17
        end
        ST_ERROR:
        begin
          if (I_START)
            state_r <= ST_IDLE;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // power-up immediate request
  // ---------------------------------------------------------------
  // set by power-up event; set wins over the clear at entry
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
      imm_pend_r <= 1'b0;
    else if (I_POWER_UP)
      imm_pend_r <= 1'b1;
    else if (state_r == ST_IDLE)
      imm_pend_r <= 1'b0;
  end

  // ---------------------------------------------------------------
  // results
  // ---------------------------------------------------------------
  // position load: home point becomes offset, unless suppressed
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      pos_r <= '0;
      load_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      cal_r <= 1'b0;
    end
    else
    begin
      load_r <= 1'b0;
      done_r <= finish;
      cal_r <= finish & run_r[F_CAL]; // R21
      if (finish && !run_r[F_NOADJ]) // R18
      begin
        pos_r <= I_HOME_OFFSET + (meth == M_IMMED ? I_ENC_POS : '0); // R11
        load_r <= 1'b1;
      end
      // a start in the error state must win, or the flag could never clear
      if (state_r == ST_ERROR && !I_START)
        err_r <= 1'b1;
      else if (I_START)
        err_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign O_MOVE = (state_r == ST_SEARCH) || (state_r == ST_BACKOUT) || (state_r == ST_INDEX)
               || (state_r == ST_AWAY) || (state_r == ST_PRESS);
  assign O_MOVE_NEG = neg_r;
  assign O_SLOW = (state_r == ST_BACKOUT) || (state_r == ST_INDEX) || (state_r == ST_AWAY);
  assign O_PRESS = (state_r == ST_PRESS) && found_r; // R08
  assign O_GOTO_ZERO = (state_r == ST_ZERO);
  assign O_POSITION = pos_r;
  assign O_POS_LOAD = load_r;
  assign O_HOME_ADJUST = adj_r;
  assign O_BUSY = (state_r != ST_IDLE) && (state_r != ST_ERROR);
  assign O_DONE = done_r;
  assign O_ERROR = err_r;
  assign O_REFUSED = ref_r;
  assign O_CAL_STORE = cal_r;
  // stored word: immediate method with the other bits kept
  assign O_CAL_CFG = {run_r[CFG_W-1:F_METH_HI+1], M_IMMED};
  assign O_CAL_OFFSET = adj_r;
endmodule : hms_seq

// *** include/hms_pkg.sv ***
package hms_pkg;
  // ---------------------------------------------------------------
  // configuration word layout
  // ---------------------------------------------------------------
  localparam int CFG_W = 16;
  localparam int POS_W = 32;
  localparam int CUR_W = 16;
  localparam int F_METH_LO = 0;
  localparam int F_METH_HI = 3;
  localparam int F_DIR = 4;
  localparam int F_IDX = 5;
  localparam int F_IDXSEL = 6;
  localparam int F_IDXFALL = 7;
  localparam int F_HOMENEG = 8;
  localparam int F_ZERO = 9;
  localparam int F_NOADJ = 10;
  localparam int F_CAL = 11;
  localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;
  // ---------------------------------------------------------------
  // method codes
  // ---------------------------------------------------------------
  localparam logic [3:0] M_HERE = 4'h0;
  localparam logic [3:0] M_LIMIT = 4'h1;
  localparam logic [3:0] M_CONST = 4'h2;
  localparam logic [3:0] M_INTER = 4'h3;
  localparam logic [3:0] M_HARD = 4'h4;
  localparam logic [3:0] M_IMMED = 4'hF;
  // ---------------------------------------------------------------
  // timing: hard-stop delay unit 1 ms
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_MHZ * TICK_US;
  localparam int DLY_W = 16;
  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_SEARCH = 4'h1,
    ST_BACKOUT = 4'h2,
    ST_INDEX = 4'h3,
    ST_PRESS = 4'h4,
    ST_AWAY = 4'h5,
    ST_DONE = 4'h6,
    ST_ZERO = 4'h7,
    ST_ERROR = 4'h8,
    ST_WAITENC = 4'h9
  } hms_state_t;
endpackage : hms_pkg

// *** include/hms_edge_if.sv ***
`timescale 1ns/1ps
// edge events of the sensors, shared between the detector and the sequencer
interface hms_edge_if;
  logic home_rise;
  logic home_fall;
  logic idx_rise;
  logic idx_fall;
  modport det (output home_rise, output home_fall, output idx_rise, output idx_fall);
  modport seq (input home_rise, input home_fall, input idx_rise, input idx_fall);
endinterface : hms_edge_if

// *** rtl/hms_edge_det.sv ***
`timescale 1ns/1ps
module hms_edge_det
  import hms_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // sensor levels
  input wire logic i_home,
  input wire logic i_index,
  // edge events
  hms_edge_if.det edges
);
  logic home_d_r;
  logic idx_d_r;

  // ---------------------------------------------------------------
  // previous levels
  // ---------------------------------------------------------------
  // one stage of history; inputs are already synchronous
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      home_d_r <= 1'b0;
      idx_d_r <= 1'b0;
    end
    else
    begin
      home_d_r <= i_home;
      idx_d_r <= i_index;
    end
  end

  // one-cycle edge pulses
  assign edges.home_rise = i_home & ~home_d_r;
  assign edges.home_fall = ~i_home & home_d_r;
  assign edges.idx_rise = i_index & ~idx_d_r;
  assign edges.idx_fall = ~i_index & idx_d_r;
endmodule : hms_edge_det

// *** testbench/hms_seq_props.sv ***
`timescale 1ns/1ps
module hms_seq_props
  import hms_pkg::*;
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RESETN,
  // inputs seen
  input wire logic I_START,
  input wire logic signed [POS_W-1:0] I_HOME_OFFSET,
  input wire logic [DLY_W-1:0] I_HOME_DELAY_MS,
  input wire logic I_LIMIT_POS,
  input wire logic I_LIMIT_NEG,
  input wire logic signed [POS_W-1:0] I_ENC_POS,
  // outputs watched
  input wire logic [CFG_W-1:0] O_CFG_RDATA,
  input wire logic O_MOVE,
  input wire logic O_MOVE_NEG,
  input wire logic O_SLOW,
  input wire logic O_PRESS,
  input wire logic O_GOTO_ZERO,
  input wire logic signed [POS_W-1:0] O_POSITION,
  input wire logic O_POS_LOAD,
  input wire logic signed [POS_W-1:0] O_HOME_ADJUST,
  input wire logic O_BUSY,
  input wire logic O_ERROR,
  input wire logic O_REFUSED,
  input wire logic O_CAL_STORE,
  input wire logic [CFG_W-1:0] O_CAL_CFG,
  input wire logic signed [POS_W-1:0] O_CAL_OFFSET
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic [31:0] press_cnt_r;
  logic [31:0] press_cnt_nxt;
  logic [31:0] press_min;
  logic [3:0] meth;
  // method field and press budget in cycles
  assign meth = O_CFG_RDATA[F_METH_HI:F_METH_LO];
  assign press_min = TICK_CYC * I_HOME_DELAY_MS;
  // count too long to unroll, so it lives in a counter
  assign press_cnt_nxt = O_PRESS ? press_cnt_r + 32'h1 : 32'h0;
  always_ff @(posedge I_CLK or negedge I_RESETN)
    if (!I_RESETN)
      press_cnt_r <= 32'h0;
    else
      press_cnt_r <= press_cnt_nxt;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  sequence s_start;
    I_START && !O_BUSY && !O_ERROR;
  endsequence
  sequence s_move_dir;
    O_MOVE && (O_MOVE_NEG == O_CFG_RDATA[F_DIR]);
  endsequence
  property p_refuse;
    s_start ##0 (meth inside {[4'h5:4'hE]}) |-> ##[1:2] O_REFUSED;
  endproperty
  a_refuse: assert property (p_refuse) else $error("reserved method not refused");
  property p_refidle;
    O_REFUSED |-> !O_BUSY && !O_MOVE;
  endproperty
  a_refidle: assert property (p_refidle) else $error("refused start still moved");
  property p_dir;
    s_start ##0 (meth inside {[4'h1:4'h4]}) |-> ##[1:2] s_move_dir;
  endproperty
  a_dir: assert property (p_dir) else $error("first move in wrong direction");
  property p_limit_err;
    (meth == M_CONST && O_MOVE && !O_SLOW && (O_MOVE_NEG ? I_LIMIT_NEG : I_LIMIT_POS)) |-> ##[1:3] O_ERROR;
  endproperty
  a_limit_err: assert property (p_limit_err) else $error("limit before home gave no error");
  property p_press;
    $fell(O_PRESS) |-> press_cnt_r >= press_min && press_cnt_r <= press_min + 32'h2;
  endproperty
  a_press: assert property (p_press) else $error("press time differs from delay");
  property p_immed;
    O_POS_LOAD && meth == M_IMMED |-> O_POSITION == I_HOME_OFFSET + I_ENC_POS;
  endproperty
  a_immed: assert property (p_immed) else $error("immediate position not offset plus encoder");
  property p_cal;
    O_CAL_STORE |-> O_CFG_RDATA[F_CAL] && O_CAL_CFG == {O_CFG_RDATA[15:4], 4'hF}
      && O_CAL_OFFSET == I_HOME_OFFSET - I_ENC_POS;
  endproperty
  a_cal: assert property (p_cal) else $error("calibration store wrong");
  property p_noadj;
    O_POS_LOAD |-> !O_CFG_RDATA[F_NOADJ];
  endproperty
  a_noadj: assert property (p_noadj) else $error("position loaded with adjust off");
  property p_zero;
    O_GOTO_ZERO |-> O_CFG_RDATA[F_ZERO] && !O_CFG_RDATA[F_NOADJ];
  endproperty
  a_zero: assert property (p_zero) else $error("move to zero not allowed");
endmodule : hms_seq_props

// *** testbench/hms_plant.sv ***
`timescale 1ns/1ps
module hms_plant
  import hms_pkg::*;
#(
  parameter int LIM = 2000
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // drive commands
  input wire logic i_move,
  input wire logic i_move_neg,
  input wire logic i_press,
  input wire logic i_goto_zero,
  // scene set by the bench
  input wire logic i_hard_en,
  input wire logic signed [POS_W-1:0] i_stop,
  input wire logic signed [POS_W-1:0] i_home_lo,
  input wire logic signed [POS_W-1:0] i_home_hi,
  // sensors
  output logic o_home_sw,
  output logic o_lim_pos,
  output logic o_lim_neg,
  output logic o_index,
  output logic [CUR_W-1:0] o_cur,
  output logic signed [POS_W-1:0] o_enc,
  output logic o_at_target
);
  // ---------------------------------------------------------------
  // axis
  // ---------------------------------------------------------------
  logic signed [POS_W-1:0] pos_r;
  logic blocked;
  // a hard stop swallows positive travel
  assign blocked = i_hard_en && !i_move_neg && pos_r >= i_stop;
  always_ff @(posedge i_clk or negedge i_resetn)
    if (!i_resetn)
      pos_r <= 32'h0;
    else if (i_move && !blocked)
      pos_r <= i_move_neg ? pos_r - 32'sh1 : pos_r + 32'sh1;
  // zero move settles one cycle after it is asked
  always_ff @(posedge i_clk or negedge i_resetn)
    if (!i_resetn)
      o_at_target <= 1'b0;
    else
      o_at_target <= i_goto_zero;
  // sensors derived from position; index once per 64 counts
  assign o_enc = pos_r;
  assign o_home_sw = pos_r >= i_home_lo && pos_r <= i_home_hi;
  assign o_lim_pos = pos_r >= LIM;
  assign o_lim_neg = pos_r <= -LIM;
  assign o_index = pos_r[5:0] == 6'h00;
  assign o_cur = (blocked && (i_move || i_press)) ? 16'h0100 : 16'h0010;
endmodule : hms_plant

// *** testbench/hms_seq_tb.sv ***
`timescale 1ns/1ps
module hms_seq_tb
  import hms_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam logic signed [POS_W-1:0] OFF = 32'h0000_0100;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_we = 1'b0;
  logic [CFG_W-1:0] cfg_wd = 16'h0000;
  logic start = 1'b0;
  logic pwr_up = 1'b0;
  logic enc_rdy = 1'b1;
  logic hard_en = 1'b0;
  logic [DLY_W-1:0] dly_ms = 16'h0001;
  logic signed [POS_W-1:0] stop = 32'h4000_0000;
  logic signed [POS_W-1:0] home_lo = 32'h4000_0000;
  logic signed [POS_W-1:0] home_hi = 32'h4000_0040;
  logic home_sw, lim_p, lim_n, idx, at_t, move, move_neg, slow, press, goto_zero;
  logic pos_load, busy, done, error, refused, cal_store;
  logic [CUR_W-1:0] cur;
  logic [CFG_W-1:0] cfg_rd, cal_cfg, ccfg;
  logic signed [POS_W-1:0] enc, position, adjust, cal_off, pos_q, coff;
  logic mv, neg, prs, zr, ld, er, rf, dn, cal;
  int fails = 0;
  int tests_run = 0;
  // 125 MHz clock
  always #4 clk = ~clk;
  hms_seq uut (.I_CLK(clk), .I_RESETN(rst_n), .I_CFG_WE(cfg_we), .I_CFG_WDATA(cfg_wd), .O_CFG_RDATA(cfg_rd),
    .I_HOME_OFFSET(OFF), .I_CUR_THRESH(16'h0080), .I_HOME_DELAY_MS(dly_ms), .I_START(start),
    .I_POWER_UP(pwr_up), .I_ENC_READY(enc_rdy), .I_HOME_SW(home_sw), .I_LIMIT_POS(lim_p),
    .I_LIMIT_NEG(lim_n), .I_INDEX(idx), .I_MOTOR_CUR(cur), .I_ENC_POS(enc), .I_AT_TARGET(at_t),
    .O_MOVE(move), .O_MOVE_NEG(move_neg), .O_SLOW(slow), .O_PRESS(press), .O_GOTO_ZERO(goto_zero),
    .O_POSITION(position), .O_POS_LOAD(pos_load), .O_HOME_ADJUST(adjust), .O_BUSY(busy), .O_DONE(done),
    .O_ERROR(error), .O_REFUSED(refused), .O_CAL_STORE(cal_store), .O_CAL_CFG(cal_cfg), .O_CAL_OFFSET(cal_off));
  hms_plant u_plant (.i_clk(clk), .i_resetn(rst_n), .i_move(move), .i_move_neg(move_neg), .i_press(press),
    .i_goto_zero(goto_zero), .i_hard_en(hard_en), .i_stop(stop), .i_home_lo(home_lo), .i_home_hi(home_hi),
    .o_home_sw(home_sw), .o_lim_pos(lim_p), .o_lim_neg(lim_n), .o_index(idx), .o_cur(cur), .o_enc(enc),
    .o_at_target(at_t));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask : chk
  task automatic fl(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : fl
  task automatic wr(input logic [CFG_W-1:0] v);
    @(posedge clk);
    cfg_we <= 1'b1;
    cfg_wd <= v;
    @(posedge clk);
    cfg_we <= 1'b0;
  endtask : wr
  task automatic go;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask : go
  // gathers what the run showed; stops nine cycles after an ending event
  task automatic watch(input int lim);
    int left;
    left = lim;
    {mv, neg, prs, zr, ld, er, rf, dn, cal} = 9'h000;
    while (left > 0)
    begin
      @(negedge clk);
      mv |= (move === 1'b1);
      neg |= (move === 1'b1 && move_neg === 1'b1);
      prs |= (press === 1'b1);
      zr |= (goto_zero === 1'b1);
      er |= (error === 1'b1);
      rf |= (refused === 1'b1);
      dn |= (done === 1'b1);
      if (pos_load === 1'b1)
      begin
        ld = 1'b1;
        pos_q = position;
      end
      if (cal_store === 1'b1)
      begin
        cal = 1'b1;
        ccfg = cal_cfg;
        coff = cal_off;
      end
      if ((dn | er | rf) && left > 10)
        left = 10;
      left--;
    end
    $display("step ended at %0t", $time);
  endtask : watch
  task automatic run(input logic [CFG_W-1:0] v, input int lim);
    wr(v);
    go();
    watch(lim);
  endtask : run
  // home switch placed relative to where the axis stands
  task automatic win(input int d);
    @(posedge clk);
    home_lo <= enc + d;
    home_hi <= enc + d + 50;
  endtask : win
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({16'h0, cfg_rd}, {16'h0, CFG_RESET});
    wr(16'h0FF0);
    @(negedge clk);
    chk({16'h0, cfg_rd}, 32'h0000_0FF0);
    run(16'h0000, 50);
    chk(pos_q, OFF);
    chk(adjust, OFF - enc);
    run(16'h0020, 400);
    fl(mv & dn, 1'b1);
    run(16'h00A0, 400);
    fl(dn, 1'b1);
    run(16'h0011, 8000);
    fl(neg & dn, 1'b1);
    win(100);
    run(16'h0002, 4000);
    fl(dn & neg, 1'b1);
    win(100);
    run(16'h0062, 4000);
    fl(dn, 1'b1);
    win(-300);
    run(16'h0002, 8000);
    fl(er & ~dn, 1'b1);
    go();
    watch(5);
    fl(error, 1'b0);
    win(-300);
    run(16'h0003, 8000);
    fl(dn & neg, 1'b1);
    win(-300);
    run(16'h0103, 8000);
    fl(dn, 1'b1);
    @(posedge clk);
    hard_en <= 1'b1;
    stop <= enc + 200;
    // a full millisecond press is too long to wait for: see it still held, then cut it by reset
    run(16'h0004, 2000);
    fl(prs & ~dn, 1'b1);
    fl(press, 1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    dly_ms <= 16'h0000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    fl(press | busy, 1'b0);
    run(16'h0004, 4000);
    fl(prs & dn, 1'b1);
    run(16'h0024, 2000);
    fl(dn & neg, 1'b1);
    hard_en <= 1'b0;
    run(16'h0200, 50);
    fl(zr & dn, 1'b1);
    run(16'h0600, 50);
    fl(ld | zr, 1'b0);
    chk(adjust, OFF - enc);
    run(16'h0800, 50);
    fl(cal, 1'b1);
    chk({16'h0, ccfg}, 32'h0000_080F);
    chk(coff, OFF - enc);
    for (int m = 5; m < 15; m++)
    begin
      run({12'h000, 4'(m)}, 30);
      fl(rf & ~mv, 1'b1);
    end
    @(posedge clk);
    enc_rdy <= 1'b0;
    wr(16'h000F);
    @(posedge clk);
    pwr_up <= 1'b1;
    @(posedge clk);
    pwr_up <= 1'b0;
    watch(20);
    fl(ld, 1'b0);
    @(posedge clk);
    enc_rdy <= 1'b1;
    watch(30);
    fl(ld, 1'b1);
    chk(pos_q, OFF + enc);
    end_sim();
  end
  // watchdog: the whole sequence needs about 12000 cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    fails++;
    end_sim();
  end
endmodule : hms_seq_tb
bind hms_seq hms_seq_props u_props (.I_CLK, .I_RESETN, .I_START, .I_HOME_OFFSET, .I_HOME_DELAY_MS, .I_LIMIT_POS,
  .I_LIMIT_NEG, .I_ENC_POS, .O_CFG_RDATA, .O_MOVE, .O_MOVE_NEG, .O_SLOW, .O_PRESS, .O_GOTO_ZERO, .O_POSITION,
  .O_POS_LOAD, .O_HOME_ADJUST, .O_BUSY, .O_ERROR, .O_REFUSED, .O_CAL_STORE, .O_CAL_CFG, .O_CAL_OFFSET);
